// ===== logic/rlt_link_test.sv
// Purpose: Link-test probe/reply engine and addressed packet framing.
// Assumes: Host and radio byte streams run on ref_clk; radio takes one byte per cycle.
// Notes: Mode pins are asynchronous and are synchronised before use.
`timescale 1ns/1ps
module rlt_link_test import rlt_pkg::*; #(
  parameter int PROBE_PERIOD = PROBE_PERIOD_CYC,
  parameter int IND_HOLD = IND_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq,
  input wire logic modeSelA,
  input wire logic modeSelB,
  input wire logic [7:0] hostInByte,
  input wire logic hostInValid,
  input wire logic hostInLast,
  output logic hostInReady,
  output logic [7:0] hostOutByte,
  output logic hostOutValid,
  output logic hostOutLast,
  input wire logic [7:0] radioRxByte,
  input wire logic radioRxValid,
  input wire logic radioRxLast,
  output logic [7:0] radioTxByte,
  output logic radioTxValid,
  output logic radioTxLast,
  output logic radioTxEn,
  output logic probeInd,
  output logic replyInd
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] hdrByte(input logic [3:0] i, input logic [31:0] nid,
                                         input logic [15:0] own);
    case (i)
      4'h0: hdrByte = nid[31:24];
      4'h1: hdrByte = nid[23:16];
      4'h2: hdrByte = nid[15:8];
      4'h3: hdrByte = nid[7:0];
      4'h4, 4'h6: hdrByte = own[15:8];
      default: hdrByte = own[7:0];
    endcase
  endfunction : hdrByte

  function automatic logic [7:0] msgChar(input logic pong, input logic [3:0] i,
                                         input logic [19:0] c);
    case (i)
      4'h0: msgChar = 8'h50;
      4'h1: msgChar = pong ? 8'h4f : 8'h49;
      4'h2: msgChar = 8'h4e;
      4'h3: msgChar = 8'h47;
      4'h4: msgChar = 8'h20;
      4'h5: msgChar = {4'h3, c[19:16]};
      4'h6: msgChar = {4'h3, c[15:12]};
      4'h7: msgChar = {4'h3, c[11:8]};
      4'h8: msgChar = {4'h3, c[7:4]};
      4'h9: msgChar = {4'h3, c[3:0]};
      4'ha: msgChar = 8'h0a;
      default: msgChar = 8'h0d;
    endcase
  endfunction : msgChar

  function automatic logic [19:0] bcdInc(input logic [19:0] c);
    logic carry;
    logic [19:0] r;
    carry = 1'b1;
    r = c;
    for (int d = 0; d < 5; d++) begin
      if (carry) begin
        if (r[d*4 +: 4] == 4'h9) begin
          r[d*4 +: 4] = 4'h0;
        end else begin
          r[d*4 +: 4] = r[d*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    bcdInc = r;
  endfunction : bcdInc

  function automatic logic [3:0] satInc(input logic [3:0] i);
    satInc = (i >= HDR_LEN) ? HDR_LEN : i + 4'h1;
  endfunction : satInc

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_r;
  logic rstN;
  logic [1:0] selA_r, selB_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rstPipe_r <= 2'h0;
    else rstPipe_r <= {rstPipe_r[0], 1'b1};
  end
  assign rstN = rstPipe_r[1];
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      selA_r <= 2'h0;
      selB_r <= 2'h0;
    end else begin
      selA_r <= {selA_r[0], modeSelA};
      selB_r <= {selB_r[0], modeSelB};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] testRole_r;
  logic netMode_r;
  logic [31:0] netId_r;
  logic [15:0] ownAddr_r;
  logic [3:0] irqStat_r, irqMask_r, irqEvt;
  logic [19:0] cnt_r;
  logic testOn, normalOn;
  assign testOn = !selB_r[1] && selA_r[1] && testRole_r != ROLE_OFF;
  assign normalOn = !selA_r[1];
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      testRole_r <= RST_TEST_ROLE;
      netMode_r <= RST_NET_MODE;
      netId_r <= RST_NET_ID;
      ownAddr_r <= RST_OWN_ADDR;
      irqMask_r <= RST_IRQ_MASK;
    end else if (regWr) begin
      case (regAddr)
        OFS_TEST_ROLE: testRole_r <= regWrData[1:0];
        OFS_NET_MODE: netMode_r <= regWrData[0];
        OFS_NET_ID: netId_r <= regWrData;
        OFS_OWN_ADDR: ownAddr_r <= regWrData[15:0];
        OFS_IRQ_MASK: irqMask_r <= regWrData[3:0];
        default: ;
      endcase
    end
  end
  // Set wins over a simultaneous write-one clear
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      irqStat_r <= 4'h0;
      irq <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~((regWr && regAddr == OFS_IRQ_STAT) ? regWrData[3:0] : 4'h0))
                   | irqEvt;
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  rlt_tx_t txSt_r, txSt_nxt;
  logic [3:0] txIdx_r, txIdx_nxt;
  logic isPong_r, isPong_nxt, pingSeen_r, periodHit;
  logic emit, emitLast, startTest, probeEvt, replyEvt;
  logic [7:0] emitByte;
  always_comb begin
    txSt_nxt = txSt_r;
    txIdx_nxt = txIdx_r;
    isPong_nxt = isPong_r;
    emit = 1'b0;
    emitLast = 1'b0;
    emitByte = 8'h00;
    case (txSt_r)
      TX_IDLE: begin
        txIdx_nxt = 4'h0;
        if (testOn && testRole_r == ROLE_MASTER && periodHit) begin
          txSt_nxt = TX_TEST;
          isPong_nxt = 1'b0;
        end else if (testOn && testRole_r == ROLE_SLAVE && pingSeen_r) begin
          txSt_nxt = TX_TEST;
          isPong_nxt = 1'b1;
        end else if (normalOn && hostInValid) begin
          txSt_nxt = TX_HOST;
        end
      end
      TX_HOST: begin
        // Network framing: id(4), destination from host(2), own address(2), payload
        if (!netMode_r || txIdx_r == 4'h4 || txIdx_r == 4'h5 || txIdx_r >= HDR_LEN) begin
          if (hostInValid && hostInReady) begin
            emit = 1'b1;
            emitByte = hostInByte;
            emitLast = hostInLast;
            txIdx_nxt = satInc(txIdx_r);
            if (hostInLast) txSt_nxt = TX_IDLE;
          end
        end else begin
          emit = 1'b1;
          emitByte = hdrByte(txIdx_r, netId_r, ownAddr_r);
          txIdx_nxt = satInc(txIdx_r);
        end
      end
      TX_TEST: begin
        emit = 1'b1;
        emitByte = msgChar(isPong_r, txIdx_r, cnt_r);
        emitLast = txIdx_r == MSG_LAST_IDX;
        txIdx_nxt = txIdx_r + 4'h1;
        if (emitLast) txSt_nxt = TX_IDLE;
      end
      default: txSt_nxt = TX_IDLE;
    endcase
  end
  assign startTest = txSt_r == TX_IDLE && txSt_nxt == TX_TEST;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      txSt_r <= TX_IDLE;
      txIdx_r <= 4'h0;
      isPong_r <= 1'b0;
      radioTxByte <= 8'h00;
      radioTxValid <= 1'b0;
      radioTxLast <= 1'b0;
      radioTxEn <= 1'b0;
      hostInReady <= 1'b0;
    end else begin
      txSt_r <= txSt_nxt;
      txIdx_r <= txIdx_nxt;
      isPong_r <= isPong_nxt;
      radioTxByte <= emitByte;
      radioTxValid <= emit;
      radioTxLast <= emitLast;
      radioTxEn <= txSt_nxt != TX_IDLE;
      hostInReady <= txSt_nxt == TX_HOST && (!netMode_r || txIdx_nxt == 4'h4
                     || txIdx_nxt == 4'h5 || txIdx_nxt >= HDR_LEN);
    end
  end

  // ----------------------------------------------------------------
  // Receive filter and test message recognition
  // ----------------------------------------------------------------
  logic [3:0] rxIdx_r;
  logic okNet_r, okOwn_r, okBc_r, pfxPing_r, pfxPong_r;
  logic rxAct, rxMatch, fwd, deliver, pingHit, pongHit;
  // Half duplex: radio bytes are ignored while transmitting
  assign rxAct = radioRxValid && txSt_r == TX_IDLE;
  assign rxMatch = okNet_r && (okOwn_r || okBc_r);
  assign fwd = rxAct && normalOn && (!netMode_r || (rxIdx_r >= SRC_IDX && rxMatch));
  assign deliver = fwd && radioRxLast;
  assign pingHit = rxAct && radioRxLast && testOn && rxIdx_r >= TAG_LEN && pfxPing_r;
  assign pongHit = rxAct && radioRxLast && testOn && rxIdx_r >= TAG_LEN && pfxPong_r;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rxIdx_r <= 4'h0;
      okNet_r <= 1'b1;
      okOwn_r <= 1'b1;
      okBc_r <= 1'b1;
      pfxPing_r <= 1'b1;
      pfxPong_r <= 1'b1;
    end else if (rxAct) begin
      if (radioRxLast) begin
        rxIdx_r <= 4'h0;
        okNet_r <= 1'b1;
        okOwn_r <= 1'b1;
        okBc_r <= 1'b1;
        pfxPing_r <= 1'b1;
        pfxPong_r <= 1'b1;
      end else begin
        rxIdx_r <= satInc(rxIdx_r);
        if (rxIdx_r < TAG_LEN) begin
          if (radioRxByte != hdrByte(rxIdx_r, netId_r, ownAddr_r)) okNet_r <= 1'b0;
          if (radioRxByte != msgChar(1'b0, rxIdx_r, cnt_r)) pfxPing_r <= 1'b0;
          if (radioRxByte != msgChar(1'b1, rxIdx_r, cnt_r)) pfxPong_r <= 1'b0;
        end else if (rxIdx_r < SRC_IDX) begin
          if (radioRxByte != hdrByte(rxIdx_r, netId_r, ownAddr_r)) okOwn_r <= 1'b0;
          if (radioRxByte != 8'hff) okBc_r <= 1'b0;
        end
      end
    end
  end
  // Sender address arrives right after the destination, so it leads the output
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      hostOutByte <= 8'h00;
      hostOutValid <= 1'b0;
      hostOutLast <= 1'b0;
    end else begin
      hostOutByte <= radioRxByte;
      hostOutValid <= fwd;
      hostOutLast <= deliver;
    end
  end

  // ----------------------------------------------------------------
  // Test counter, probe timer and indicators
  // ----------------------------------------------------------------
  logic [31:0] period_r, probeHold_r, replyHold_r;
  assign periodHit = period_r == 32'(PROBE_PERIOD - 1);
  assign probeEvt = (emitLast && txSt_r == TX_TEST && !isPong_r)
                    || (testRole_r == ROLE_SLAVE && pingHit);
  assign replyEvt = (emitLast && txSt_r == TX_TEST && isPong_r)
                    || (testRole_r == ROLE_MASTER && pongHit);
  assign irqEvt = {!deliver && rxAct && radioRxLast && normalOn, deliver, replyEvt, probeEvt};
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      period_r <= 32'h0;
      cnt_r <= 20'h0;
      pingSeen_r <= 1'b0;
    end else begin
      period_r <= (periodHit || !(testOn && testRole_r == ROLE_MASTER)) ? 32'h0
                  : period_r + 32'h1;
      pingSeen_r <= testRole_r == ROLE_SLAVE && pingHit;
      if (probeEvt) cnt_r <= bcdInc(cnt_r);
    end
  end
  // Pulses other than the slave's probe pulse are shortened by the next exchange so each one stays distinct
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      probeHold_r <= 32'h0;
      replyHold_r <= 32'h0;
      probeInd <= 1'b0;
      replyInd <= 1'b0;
    end else begin
      if (probeEvt) probeHold_r <= 32'(IND_HOLD);
      else if (startTest && !isPong_nxt) probeHold_r <= 32'h0;
      else if (probeHold_r != 32'h0) probeHold_r <= probeHold_r - 32'h1;
      if (replyEvt) replyHold_r <= 32'(IND_HOLD);
      else if (probeEvt) replyHold_r <= 32'h0;
      else if (replyHold_r != 32'h0) replyHold_r <= replyHold_r - 32'h1;
      probeInd <= probeEvt || (probeHold_r > 32'h1 && !(startTest && !isPong_nxt));
      replyInd <= replyEvt || (replyHold_r > 32'h1 && !probeEvt);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) regRdData <= 32'h0;
    else if (regRd) begin
      case (regAddr)
        OFS_TEST_ROLE: regRdData <= {30'h0, testRole_r};
        OFS_NET_MODE: regRdData <= {31'h0, netMode_r};
        OFS_NET_ID: regRdData <= netId_r;
        OFS_OWN_ADDR: regRdData <= {16'h0, ownAddr_r};
        OFS_STATUS: regRdData <= {27'h0, replyInd, probeInd, normalOn, testOn, radioTxEn};
        OFS_IRQ_STAT: regRdData <= {28'h0, irqStat_r};
        OFS_IRQ_MASK: regRdData <= {28'h0, irqMask_r};
        OFS_COUNT: regRdData <= {12'h0, cnt_r};
        default: regRdData <= 32'h0;
      endcase
    end else regRdData <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);
  // Run length of valid non-final radio bytes; a long repeat would be too costly to unroll
  logic [3:0] txRun_r;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) txRun_r <= 4'h0;
    else if (!radioTxValid || radioTxLast) txRun_r <= 4'h0;
    else if (txRun_r != 4'hf) txRun_r <= txRun_r + 4'h1;
  end
  sequence s_testEnd;
    ##12 (radioTxValid && radioTxLast && txRun_r == MSG_LAST_IDX);
  endsequence
  sequence s_testMsg;
    s_testEnd ##1 !radioTxValid;
  endsequence
  property p_msgLen; startTest |=> s_testMsg; endproperty
  a_msgLen: assert property (p_msgLen) else $error("test message not 12 bytes");
  property p_pingHead; startTest && !isPong_nxt |=> ##1 radioTxByte == 8'h50 ##1 radioTxByte == 8'h49;
  endproperty
  a_pingHead: assert property (p_pingHead) else $error("probe text wrong");
  property p_pongHead; startTest && isPong_nxt |=> ##2 radioTxByte == 8'h4f; endproperty
  a_pongHead: assert property (p_pongHead) else $error("reply text wrong");
  property p_testRole; startTest |-> testOn && testRole_r != ROLE_OFF; endproperty
  a_testRole: assert property (p_testRole) else $error("test send outside test mode");
  property p_probeInd; probeEvt |=> probeInd; endproperty
  a_probeInd: assert property (p_probeInd) else $error("probe indicator missed");
  property p_replyInd; replyEvt |=> replyInd ##1 !probeEvt [*1]; endproperty
  a_replyInd: assert property (p_replyInd) else $error("reply indicator missed");
  property p_count; probeEvt |=> cnt_r != $past(cnt_r); endproperty
  a_count: assert property (p_count) else $error("counter did not advance");
  property p_autoTx; txSt_r == TX_IDLE && normalOn && hostInValid |=> radioTxEn; endproperty
  a_autoTx: assert property (p_autoTx) else $error("no transmit after host data");
  property p_idleRx; txSt_r == TX_IDLE |-> !radioTxEn; endproperty
  a_idleRx: assert property (p_idleRx) else $error("transmit while idle");
  property p_filter; hostOutValid && netMode_r |-> $past(rxMatch) && $past(rxIdx_r) >= SRC_IDX;
  endproperty
  a_filter: assert property (p_filter) else $error("unmatched packet forwarded");
endmodule : rlt_link_test

// ===== logic/rlt_pkg.sv
// Purpose: Shared constants for the radio link test and addressing block.
// Assumes: 100 MHz ref_clk; 32-bit register port with byte addresses.
// Notes: Counts above 4096 cycles also appear as top-level parameters.
package rlt_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PROBE_PERIOD_MS = 1000;
  localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int IND_HOLD_US = 1000;
  localparam int IND_HOLD_CYC = IND_HOLD_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TEST_ROLE = 8'h00;
  localparam logic [7:0] OFS_NET_MODE = 8'h04;
  localparam logic [7:0] OFS_NET_ID = 8'h08;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_COUNT = 8'h1c;
  localparam logic [1:0] RST_TEST_ROLE = 2'h0;
  localparam logic RST_NET_MODE = 1'b0;
  localparam logic [31:0] RST_NET_ID = 32'h0000_0000;
  localparam logic [15:0] RST_OWN_ADDR = 16'h0000;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  // Interrupt status bits
  localparam int IRQ_PROBE = 0;
  localparam int IRQ_REPLY = 1;
  localparam int IRQ_DELIVER = 2;
  localparam int IRQ_DISCARD = 3;
  // ----------------------------------------------------------------
  // Roles, addresses, message layout
  // ----------------------------------------------------------------
  localparam logic [1:0] ROLE_OFF = 2'h0;
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_SLAVE = 2'h2;
  localparam logic [15:0] BCAST_ADDR = 16'hffff;
  localparam logic [3:0] MSG_LAST_IDX = 4'hb;
  localparam logic [3:0] HDR_LEN = 4'h8;
  localparam logic [3:0] SRC_IDX = 4'h6;
  localparam logic [3:0] TAG_LEN = 4'h4;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_HOST = 3'b010,
    TX_TEST = 3'b100
  } rlt_tx_t;
endpackage : rlt_pkg

// ===== sim/rlt_host_model.sv
// Purpose: Host controller model on the byte-wide serial side of the unit.
// Assumes: Bytes are offered just after a rising edge and held until taken or 100 edges pass.
// Notes: Idle data shows the inverse of the last byte, never a stale copy.
`timescale 1ns/1ps
module rlt_host_model (
  input wire logic ref_clk,
  output logic [7:0] hostInByte,
  output logic hostInValid,
  output logic hostInLast,
  input wire logic hostInReady,
  input wire logic [7:0] hostOutByte,
  input wire logic hostOutValid,
  input wire logic hostOutLast
);
  logic [7:0] outQ[$];
  int nLast = 0;
  int nStall = 0;
  initial begin
    hostInByte = 8'h00;
    hostInValid = 1'b0;
    hostInLast = 1'b0;
  end
  always @(posedge ref_clk) begin
    if (hostOutValid === 1'b1) begin
      outQ.push_back(hostOutByte);
    end
    if (hostOutLast === 1'b1) begin
      nLast++;
    end
  end
  // Each byte stays put until the unit's ready is seen at an edge or 100 edges pass
  task automatic send_pkt(input logic [7:0] b[$]);
    int k;
    foreach (b[i]) begin
      hostInByte <= b[i];
      hostInLast <= (i == b.size() - 1);
      hostInValid <= 1'b1;
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (hostInReady !== 1'b1 && k < 100);
      if (hostInReady !== 1'b1) nStall++;
    end
    hostInValid <= 1'b0;
    hostInLast <= 1'b0;
    hostInByte <= ~b[b.size() - 1];
  endtask : send_pkt
  task automatic send_addr(input logic [15:0] dest, input logic [7:0] pay[$]);
    pay.push_front(dest[7:0]);
    pay.push_front(dest[15:8]);
    send_pkt(pay);
  endtask : send_addr
endmodule : rlt_host_model

// ===== sim/rlt_link_test_tb.sv
// Purpose: Self-checking bench for the link-test and addressing block.
// Assumes: Short probe period and indicator hold keep the run brief.
// Notes: Test-mode counts assume the counter restarts at each reset.
`timescale 1ns/1ps
module rlt_link_test_tb;
  import rlt_pkg::*;
  typedef logic [7:0] rlt_bq_t[$];
  localparam int PERIOD = 200;
  localparam int HOLD = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic modeSelA = 1'b0;
  logic modeSelB = 1'b1;
  logic [7:0] radioRxByte = 8'h00;
  logic radioRxValid = 1'b0;
  logic radioRxLast = 1'b0;
  logic [31:0] regRdData;
  logic irq, hostInValid, hostInLast, hostInReady, hostOutValid, hostOutLast;
  logic [7:0] hostInByte, hostOutByte, radioTxByte;
  logic radioTxValid, radioTxLast, radioTxEn, probeInd, replyInd;
  int fails = 0;
  int n_checks = 0;
  int k;
  int nTxLast = 0;
  rlt_bq_t txQ;
  always #5 ref_clk = ~ref_clk;
  rlt_link_test #(.PROBE_PERIOD(PERIOD), .IND_HOLD(HOLD)) rlt_link_test_i (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
    .modeSelA(modeSelA), .modeSelB(modeSelB), .hostInByte(hostInByte),
    .hostInValid(hostInValid), .hostInLast(hostInLast), .hostInReady(hostInReady),
    .hostOutByte(hostOutByte), .hostOutValid(hostOutValid), .hostOutLast(hostOutLast),
    .radioRxByte(radioRxByte), .radioRxValid(radioRxValid), .radioRxLast(radioRxLast),
    .radioTxByte(radioTxByte), .radioTxValid(radioTxValid), .radioTxLast(radioTxLast),
    .radioTxEn(radioTxEn), .probeInd(probeInd), .replyInd(replyInd));
  rlt_host_model rlt_host_model_i (
    .ref_clk(ref_clk), .hostInByte(hostInByte), .hostInValid(hostInValid),
    .hostInLast(hostInLast), .hostInReady(hostInReady), .hostOutByte(hostOutByte),
    .hostOutValid(hostOutValid), .hostOutLast(hostOutLast));
  always @(posedge ref_clk) begin
    if (radioTxValid === 1'b1) begin
      txQ.push_back(radioTxByte);
    end
    if (radioTxLast === 1'b1) begin
      nTxLast++;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_q(input rlt_bq_t got, input rlt_bq_t exp);
    chk(32'(got.size()), 32'(exp.size()));
    foreach (exp[i]) chk({24'h0, got[i]}, {24'h0, exp[i]});
  endtask : chk_q
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    chk(regRdData, exp);
  endtask : rd_chk
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset
  task automatic radio_pkt(input rlt_bq_t b);
    foreach (b[i]) begin
      radioRxByte <= b[i];
      radioRxValid <= 1'b1;
      radioRxLast <= (i == b.size() - 1);
      @(posedge ref_clk);
    end
    radioRxValid <= 1'b0;
    radioRxLast <= 1'b0;
    radioRxByte <= ~b[b.size() - 1];
    repeat (4) @(posedge ref_clk);
  endtask : radio_pkt
  task automatic wait_tx(input int n);
    for (k = 0; k < 3 * PERIOD && txQ.size() < n; k++) @(posedge ref_clk);
    for (k = 0; k < 50 && radioTxEn !== 1'b0; k++) @(posedge ref_clk);
  endtask : wait_tx
  function automatic rlt_bq_t s2q(input string s);
    rlt_bq_t q;
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
    return q;
  endfunction : s2q
  function automatic rlt_bq_t pkt(input logic [31:0] net, input logic [15:0] dst);
    rlt_bq_t q;
    q = '{net[31:24], net[23:16], net[15:8], net[7:0], dst[15:8], dst[7:0], 8'h00, 8'h02};
    return {q, s2q("hi")};
  endfunction : pkt
  task automatic endt(input string s);
    $display("test %s done, mismatches so far %0d", s, fails);
    txQ.delete();
    rlt_host_model_i.outQ.delete();
  endtask : endt
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk(OFS_TEST_ROLE, 32'(RST_TEST_ROLE));
    rd_chk(OFS_NET_ID, RST_NET_ID);
    rd_chk(OFS_IRQ_MASK, 32'(RST_IRQ_MASK));
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    chk(radioTxEn, 1'b0);
    rlt_host_model_i.send_pkt('{8'h11, 8'h22, 8'h33});
    wait_tx(3);
    chk_q(txQ, '{8'h11, 8'h22, 8'h33});
    chk(radioTxEn, 1'b0);
    endt("plain");
    wr(OFS_NET_MODE, 32'h1);
    wr(OFS_NET_ID, 32'h0000_000a);
    wr(OFS_OWN_ADDR, 32'h1234_0001);
    rd_chk(OFS_OWN_ADDR, 32'h0000_0001);
    rlt_host_model_i.send_addr(16'h0002, s2q("ab"));
    wait_tx(10);
    chk_q(txQ, {8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h02, 8'h00, 8'h01, s2q("ab")});
    endt("addressed send");
    wr(OFS_IRQ_MASK, 32'h4);
    radio_pkt(pkt(32'h0000_000a, 16'h0001));
    chk_q(rlt_host_model_i.outQ, {8'h00, 8'h02, s2q("hi")});
    chk(irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h4);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    radio_pkt(pkt(32'h0000_000a, 16'h0003));
    radio_pkt(pkt(32'h0000_000b, 16'h0001));
    chk(32'(rlt_host_model_i.outQ.size()), 32'h4);
    rd_chk(OFS_IRQ_STAT, 32'h1 << IRQ_DISCARD);
    chk(irq, 1'b0);
    radio_pkt(pkt(32'h0000_000a, BCAST_ADDR));
    chk_q(rlt_host_model_i.outQ, {8'h00, 8'h02, s2q("hi"), 8'h00, 8'h02, s2q("hi")});
    chk(32'(rlt_host_model_i.nLast), 32'h2);
    endt("addressed receive");
    do_reset();
    modeSelA <= 1'b1;
    modeSelB <= 1'b0;
    repeat (PERIOD + 50) @(posedge ref_clk);
    chk(32'(txQ.size()), 32'h0);
    wr(OFS_TEST_ROLE, 32'(ROLE_MASTER));
    wait_tx(12);
    chk_q(txQ, s2q("PING 00000\n\r"));
    chk(probeInd, 1'b1);
    rd_chk(OFS_COUNT, 32'h1);
    txQ.delete();
    for (k = 0; k < HOLD + 10 && probeInd !== 1'b0; k++) @(posedge ref_clk);
    chk(probeInd, 1'b0);
    radio_pkt(s2q("PONG 00001\n\r"));
    chk(replyInd, 1'b1);
    wait_tx(12);
    chk_q(txQ, s2q("PING 00001\n\r"));
    chk(32'(rlt_host_model_i.outQ.size()), 32'h0);
    endt("master");
    wr(OFS_TEST_ROLE, 32'(ROLE_OFF));
    do_reset();
    wr(OFS_TEST_ROLE, 32'(ROLE_SLAVE));
    repeat (5) @(posedge ref_clk);
    radio_pkt(s2q("PING 00000\n\r"));
    chk(probeInd, 1'b1);
    wait_tx(12);
    chk_q(txQ, s2q("PONG 00001\n\r"));
    chk(replyInd, 1'b1);
    endt("slave");
    chk(32'(nTxLast), 32'h5);
    chk(32'(rlt_host_model_i.nStall), 32'h0);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule : rlt_link_test_tb
